// ===== bprx_classifier.sv
// Behaviour
// - High full bit needs min < duration < max
// - Low full bit needs min < duration < max
// - High half bit needs min < duration < max
// - Low half bit needs min < duration < max
// - Eight 8-bit read/write windows, zero at reset
// - Soft reset clears logic, keeps windows
`timescale 1ns/100ps
`default_nettype none
`include "bprx_params.svh"

module bprx_classifier #(
  parameter int DUR_W = 9
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [15:0]      s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output var  logic             s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output var  logic             s_axi_wready,
  output var  logic [1:0]       s_axi_bresp,
  output var  logic             s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [15:0]      s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output var  logic             s_axi_arready,
  output var  logic [31:0]      s_axi_rdata,
  output var  logic [1:0]       s_axi_rresp,
  output var  logic             s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic             cc_rx,
  output var  logic             sym_valid,
  output var  logic             sym_level,
  output var  logic             sym_full,
  output var  logic             sym_half,
  output var  logic             sym_violation,
  output var  logic [DUR_W-1:0] sym_duration
);

  import bprx_pkg::*;

  typedef struct packed {
    logic                 cc_meta;
    logic                 cc_sync;
    bprx_win_t [7:0]      win;
    logic                 soft_reset;
    logic                 aw_have;
    logic [15:0]          awaddr;
    logic                 w_have;
    logic [7:0]           wdata;
    logic                 wstb;
    logic                 awready;
    logic                 wready;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [1:0]           rresp;
    logic [31:0]          rdata;
    logic                 sym_valid;
    logic                 sym_level;
    logic                 sym_full;
    logic                 sym_half;
    logic                 sym_viol;
    logic [DUR_W-1:0]     sym_dur;
  } bprx_state_t;

  bprx_state_t      q;
  bprx_state_t      d;
  logic             ev_valid;
  logic             ev_level;
  logic [DUR_W-1:0] ev_dur;
  logic             run_n;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic bprx_sel_t decode(input logic [15:0] addr);
    bprx_sel_t sel;
    sel = BPRX_SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      unique case (addr[15:2])
        `BPRX_IDX_HIGH_FULL_BIT_MAX: sel = BPRX_SEL_HFMAX;
        `BPRX_IDX_HIGH_FULL_BIT_MIN: sel = BPRX_SEL_HFMIN;
        `BPRX_IDX_LOW_FULL_BIT_MAX:  sel = BPRX_SEL_LFMAX;
        `BPRX_IDX_LOW_FULL_BIT_MIN:  sel = BPRX_SEL_LFMIN;
        `BPRX_IDX_HIGH_HALF_BIT_MAX: sel = BPRX_SEL_HHMAX;
        `BPRX_IDX_HIGH_HALF_BIT_MIN: sel = BPRX_SEL_HHMIN;
        `BPRX_IDX_LOW_HALF_BIT_MAX:  sel = BPRX_SEL_LHMAX;
        `BPRX_IDX_LOW_HALF_BIT_MIN:  sel = BPRX_SEL_LHMIN;
        `BPRX_IDX_CODER_CTRL:        sel = BPRX_SEL_CTRL;
        `BPRX_IDX_CODER_STATUS:      sel = BPRX_SEL_STAT;
        default:                     sel = BPRX_SEL_NONE;
      endcase
    end
    return sel;
  endfunction

  // Strict window: both limits excluded
  function automatic logic in_window(input logic [DUR_W-1:0] dur,
                                     input bprx_win_t        lo,
                                     input bprx_win_t        hi);
    return (dur > DUR_W'(lo)) && (dur < DUR_W'(hi));
  endfunction

  // Slot of a window register in the packed window array
  function automatic logic [2:0] win_idx(input bprx_sel_t sel);
    return sel[2:0];
  endfunction

  // Status word: flags and duration of the last symbol
  function automatic logic [31:0] status_word(input logic             level,
                                              input logic             full,
                                              input logic             half,
                                              input logic             viol,
                                              input logic [DUR_W-1:0] dur);
    logic [31:0] w;
    w                                                = 32'h0000_0000;
    w[`BPRX_STAT_LEVEL_BIT]                          = level;
    w[`BPRX_STAT_FULL_BIT]                           = full;
    w[`BPRX_STAT_HALF_BIT]                           = half;
    w[`BPRX_STAT_VIOL_BIT]                           = viol;
    w[`BPRX_STAT_DUR_LSB+DUR_W-1:`BPRX_STAT_DUR_LSB] = dur;
    return w;
  endfunction

  // Full and half window hits for one level
  function automatic logic [1:0] classify(input logic             level,
                                          input logic [DUR_W-1:0] dur,
                                          input bprx_win_t [7:0]  win);
    logic full;
    logic half;
    if (level) begin
      full = in_window(dur, win[win_idx(BPRX_SEL_HFMIN)], win[win_idx(BPRX_SEL_HFMAX)]);
      half = in_window(dur, win[win_idx(BPRX_SEL_HHMIN)], win[win_idx(BPRX_SEL_HHMAX)]);
    end else begin
      full = in_window(dur, win[win_idx(BPRX_SEL_LFMIN)], win[win_idx(BPRX_SEL_LFMAX)]);
      half = in_window(dur, win[win_idx(BPRX_SEL_LHMIN)], win[win_idx(BPRX_SEL_LHMAX)]);
    end
    return {full, half};
  endfunction

  // --------------------------------------------------------------------------
  // Level timer, held idle by bus reset or soft reset
  // --------------------------------------------------------------------------
  assign run_n = aresetn && !q.soft_reset;

  bprx_level_timer #(
    .DUR_W (DUR_W)
  ) u_timer (
    .aclk     (aclk),
    .run_n    (run_n),
    .level    (q.cc_sync),
    .ev_valid (ev_valid),
    .ev_level (ev_level),
    .ev_dur   (ev_dur)
  );

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    bprx_sel_t wsel;
    bprx_sel_t rsel;
    logic      full;
    logic      half;
    wsel      = decode(q.awaddr);
    rsel      = decode(s_axi_araddr);
    full      = 1'b0;
    half      = 1'b0;
    d         = q;
    d.cc_meta = cc_rx;
    d.cc_sync = q.cc_meta;

    // ------------------------------------------------------------------------
    // Write address and data taken in either order
    // ------------------------------------------------------------------------
    if (s_axi_awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.wdata  = s_axi_wdata[7:0];
      d.wstb   = s_axi_wstrb[0];
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_have && q.w_have && !q.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = `BPRX_RESP_OKAY;
      if (wsel == BPRX_SEL_NONE) begin
        d.bresp = `BPRX_RESP_SLVERR;
      end else if (wsel == BPRX_SEL_CTRL) begin
        if (q.wstb) begin
          d.soft_reset = q.wdata[`BPRX_CTRL_SOFT_RESET_BIT];
        end
      end else if (wsel != BPRX_SEL_STAT) begin
        if (q.wstb) begin
          d.win[win_idx(wsel)] = q.wdata;
        end
      end
    end
    d.awready = !d.aw_have && !d.bvalid;
    d.wready  = !d.w_have && !d.bvalid;

    // ------------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------------
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp  = `BPRX_RESP_OKAY;
      d.rdata  = 32'h0000_0000;
      if (rsel == BPRX_SEL_NONE) begin
        d.rresp = `BPRX_RESP_SLVERR;
      end else if (rsel == BPRX_SEL_CTRL) begin
        d.rdata[`BPRX_CTRL_SOFT_RESET_BIT] = q.soft_reset;
      end else if (rsel == BPRX_SEL_STAT) begin
        d.rdata = status_word(q.sym_level, q.sym_full, q.sym_half, q.sym_viol, q.sym_dur);
      end else begin
        d.rdata[7:0] = q.win[win_idx(rsel)];
      end
    end
    d.arready = !d.rvalid;

    // ------------------------------------------------------------------------
    // Pulse classification
    // ------------------------------------------------------------------------
    d.sym_valid = 1'b0;
    if (ev_valid) begin
      {full, half} = classify(ev_level, ev_dur, q.win);
      d.sym_valid = 1'b1;
      d.sym_level = ev_level;
      d.sym_full  = full;
      d.sym_half  = half;
      d.sym_viol  = !full && !half;
      d.sym_dur   = ev_dur;
    end

    // ------------------------------------------------------------------------
    // Soft reset clears decode state only
    // ------------------------------------------------------------------------
    if (q.soft_reset) begin
      d.sym_valid = 1'b0;
      d.sym_level = 1'b0;
      d.sym_full  = 1'b0;
      d.sym_half  = 1'b0;
      d.sym_viol  = 1'b0;
      d.sym_dur   = '0;
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q            <= '0;
      q.win        <= {8{`BPRX_WIN_RESET}};
      q.soft_reset <= `BPRX_CTRL_RESET;
    end else begin
      q <= d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rresp   = q.rresp;
  assign s_axi_rdata   = q.rdata;
  assign sym_valid     = q.sym_valid;
  assign sym_level     = q.sym_level;
  assign sym_full      = q.sym_full;
  assign sym_half      = q.sym_half;
  assign sym_violation = q.sym_viol;
  assign sym_duration  = q.sym_dur;

endmodule

`default_nettype wire

// ===== bprx_params.svh
`ifndef BPRX_PARAMS_SVH
`define BPRX_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define BPRX_IDX_HIGH_FULL_BIT_MAX 14'h1aa0
`define BPRX_IDX_HIGH_FULL_BIT_MIN 14'h1aa1
`define BPRX_IDX_LOW_FULL_BIT_MAX  14'h1aa2
`define BPRX_IDX_LOW_FULL_BIT_MIN  14'h1aa3
`define BPRX_IDX_HIGH_HALF_BIT_MAX 14'h1aa4
`define BPRX_IDX_HIGH_HALF_BIT_MIN 14'h1aa5
`define BPRX_IDX_LOW_HALF_BIT_MAX  14'h1aa6
`define BPRX_IDX_LOW_HALF_BIT_MIN  14'h1aa7
`define BPRX_IDX_CODER_CTRL        14'h1a9e
`define BPRX_IDX_CODER_STATUS      14'h1a9f

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BPRX_CTRL_SOFT_RESET_BIT   0
`define BPRX_STAT_LEVEL_BIT        0
`define BPRX_STAT_FULL_BIT         1
`define BPRX_STAT_HALF_BIT         2
`define BPRX_STAT_VIOL_BIT         3
`define BPRX_STAT_DUR_LSB          8

// ----------------------------------------------------------------------------
// Reset values and responses
// ----------------------------------------------------------------------------
`define BPRX_WIN_RESET             8'h00
`define BPRX_CTRL_RESET            1'b0
`define BPRX_RESP_OKAY             2'h0
`define BPRX_RESP_SLVERR           2'h2

`endif

// ===== bprx_pkg.sv
package bprx_pkg;

  typedef logic [7:0] bprx_win_t;

  // Register selector produced by the address decoder
  typedef enum logic [3:0] {
    BPRX_SEL_HFMAX = 4'h0,
    BPRX_SEL_HFMIN = 4'h1,
    BPRX_SEL_LFMAX = 4'h2,
    BPRX_SEL_LFMIN = 4'h3,
    BPRX_SEL_HHMAX = 4'h4,
    BPRX_SEL_HHMIN = 4'h5,
    BPRX_SEL_LHMAX = 4'h6,
    BPRX_SEL_LHMIN = 4'h7,
    BPRX_SEL_CTRL  = 4'h8,
    BPRX_SEL_STAT  = 4'h9,
    BPRX_SEL_NONE  = 4'hf
  } bprx_sel_t;

endpackage

// ===== bprx_level_timer.sv
`timescale 1ns/100ps
`default_nettype none

module bprx_level_timer #(
  parameter int DUR_W = 9
) (
  input  wire logic             aclk,
  input  wire logic             run_n,
  input  wire logic             level,
  output var  logic             ev_valid,
  output var  logic             ev_level,
  output var  logic [DUR_W-1:0] ev_dur
);

  import bprx_pkg::*;

  typedef struct packed {
    logic             prev;
    logic             armed;
    logic [DUR_W-1:0] cnt;
    logic             ev_valid;
    logic             ev_level;
    logic [DUR_W-1:0] ev_dur;
  } bprx_tmr_t;

  localparam logic [DUR_W-1:0] CNT_ONE = DUR_W'(1);
  localparam logic [DUR_W-1:0] CNT_SAT = {DUR_W{1'b1}};

  bprx_tmr_t q;
  bprx_tmr_t d;

  // --------------------------------------------------------------------------
  // Level duration counter
  // --------------------------------------------------------------------------
  always_comb begin
    d          = q;
    d.ev_valid = 1'b0;
    if (level != q.prev) begin
      // First edge after reset only starts timing
      d.ev_valid = q.armed;
      d.ev_level = q.prev;
      d.ev_dur   = q.cnt;
      d.armed    = 1'b1;
      d.prev     = level;
      d.cnt      = CNT_ONE;
    end else if (q.cnt != CNT_SAT) begin
      d.cnt = q.cnt + CNT_ONE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!run_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign ev_valid = q.ev_valid;
  assign ev_level = q.ev_level;
  assign ev_dur   = q.ev_dur;

endmodule

`default_nettype wire

// ===== bprx_classifier_properties.sv
`timescale 1ns/100ps
`default_nettype none
module bprx_classifier_chk #(
  parameter int DUR_W = 9
) (
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_wready,
  input wire logic [1:0]       s_axi_bresp,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic [1:0]       s_axi_rresp,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  input wire logic             sym_valid,
  input wire logic             sym_full,
  input wire logic             sym_half,
  input wire logic             sym_violation,
  input wire logic [DUR_W-1:0] sym_duration
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_viol_excl: assert property (sym_valid |-> sym_violation == !(sym_full || sym_half))
    else $error("violation flag disagrees with window flags");
  a_window_strict: assert property (sym_valid && (sym_full || sym_half) |-> sym_duration != 0 && sym_duration < 255)
    else $error("accepted duration outside any 8-bit window");
  a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_r_drop: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
    else $error("read answer withdrawn without ready");
  a_b_drop: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
    else $error("write answer withdrawn without ready");
  a_r_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:17] == 15'h0)
    else $error("upper read bits not zero");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  a_w_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answer pending");
  a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
endmodule

bind bprx_classifier bprx_classifier_chk #(.DUR_W(DUR_W)) u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sym_valid, .sym_full, .sym_half, .sym_violation,
  .sym_duration);
`default_nettype wire

// ===== bprx_bmc_src.sv
`timescale 1ns/100ps
`default_nettype none
module bprx_bmc_src (
  input  wire logic aclk,
  output var  logic cc_rx
);
  initial cc_rx = 1'b0;

  // Ends the current level, holds the new one n cycles
  task automatic pulse(input int n);
    cc_rx <= ~cc_rx;
    repeat (n) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "bprx_params.svh"
module tb_top;
  import bprx_pkg::*;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cc_rx;
  logic        sym_valid, sym_level, sym_full, sym_half, sym_violation, lvl;
  logic [8:0]  sym_duration;
  logic [12:0] q [$];
  int          errors, n_tests, k;
  localparam logic [15:0] CTRL_A = {`BPRX_IDX_CODER_CTRL, 2'b00};
  localparam logic [15:0] STAT_A = {`BPRX_IDX_CODER_STATUS, 2'b00};
  bprx_win_t   win [8] = '{8'hca, 8'h74, 8'h96, 8'h64, 8'h6e, 8'h30, 8'h5a, 8'h1e};
  int          tbl [16] = '{116, 100, 117, 101, 201, 149, 202, 150, 48, 30, 49, 31, 109, 89, 110, 90};

  bprx_classifier #(.DUR_W(9)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cc_rx, .sym_valid,
    .sym_level, .sym_full, .sym_half, .sym_violation, .sym_duration);
  bprx_bmc_src src (.aclk, .cc_rx);

  always #50 aclk = ~aclk;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out;
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic hung;
    if (k >= 64) begin
      errors++;
      close_out();
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && k < 64);
    s_axi_bready <= 1'b0;
    hung();
    chk("bresp", 32'(er), 32'(s_axi_bresp));
    // Idle edge between transfers
    @(posedge aclk);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && k < 64);
    s_axi_rready <= 1'b0;
    hung();
    chk("rresp", 32'(er), 32'(s_axi_rresp));
    chk("rdata", ed, s_axi_rdata);
    @(posedge aclk);
  endtask

  function automatic logic [15:0] radr(input int i);
    return {`BPRX_IDX_HIGH_FULL_BIT_MAX + 14'(i), 2'b00};
  endfunction

  task automatic step(input int n, input bit rep);
    logic f, h;
    lvl = ~lvl;
    f = win[lvl ? 1 : 3] < n && n < win[lvl ? 0 : 2];
    h = win[lvl ? 5 : 7] < n && n < win[lvl ? 4 : 6];
    if (rep) q.push_back({lvl, f, h, !(f || h), 9'(n)});
    src.pulse(n);
  endtask

  always @(posedge aclk)
    if (aresetn && sym_valid === 1'b1) begin
      if (q.size() == 0) chk("unexpected symbol", 32'h0, 32'h1);
      else chk("symbol", 32'(q.pop_front()), {19'h0, sym_level, sym_full, sym_half, sym_violation, sym_duration});
    end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    aclk          = 1'b0;
    aresetn       = 1'b0;
    s_axi_awaddr  = 16'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata   = 32'h0;
    s_axi_wstrb   = 4'hf;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b0;
    s_axi_araddr  = 16'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b0;
    lvl           = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 8; i++) rd(radr(i), 32'h0, `BPRX_RESP_OKAY);
    rd(CTRL_A, 32'h0, `BPRX_RESP_OKAY);
    rd(16'h0000, 32'h0, `BPRX_RESP_SLVERR);
    rd(radr(0) + 16'h1, 32'h0, `BPRX_RESP_SLVERR);
    wr(16'h0000, 32'h5a, `BPRX_RESP_SLVERR);
    for (int i = 0; i < 8; i++) wr(radr(i), {24'hffffff, win[i]}, `BPRX_RESP_OKAY);
    s_axi_wstrb <= 4'he;
    wr(radr(0), 32'h0, `BPRX_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    for (int i = 0; i < 8; i++) rd(radr(i), {24'h0, win[i]}, `BPRX_RESP_OKAY);
    foreach (tbl[i]) step(tbl[i], 1'b1);
    step(50, 1'b0);
    wr(STAT_A, 32'hff, `BPRX_RESP_OKAY);
    rd(STAT_A, (32'(tbl[15]) << `BPRX_STAT_DUR_LSB) | (32'h1 << `BPRX_STAT_VIOL_BIT), `BPRX_RESP_OKAY);
    wr(CTRL_A, 32'h1, `BPRX_RESP_OKAY);
    step(40, 1'b0);
    rd(CTRL_A, 32'h1, `BPRX_RESP_OKAY);
    rd(STAT_A, 32'h0, `BPRX_RESP_OKAY);
    rd(radr(0), {24'h0, win[0]}, `BPRX_RESP_OKAY);
    wr(CTRL_A, 32'h0, `BPRX_RESP_OKAY);
    step(117, 1'b1);
    step(60, 1'b1);
    step(10, 1'b0);
    repeat (8) @(posedge aclk);
    chk("pending symbols", 32'h0, 32'(q.size()));
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 8; i++) rd(radr(i), 32'h0, `BPRX_RESP_OKAY);
    rd(CTRL_A, 32'h0, `BPRX_RESP_OKAY);
    close_out();
  end
endmodule
`default_nettype wire
